/* File: logic/pvip_pkg.sv */
// Constants shared by the parallel video input port and its control filter.
// Assumes register indices are word indices: byte address is four times the index.
package pvip_pkg;

	// -------------------------------------------------------------------
	// Clock and timing
	// -------------------------------------------------------------------
	localparam int unsigned SYS_CLK_MHZ  = 200;
	localparam int unsigned LOCK_TIME_NS = 1000;
	localparam int unsigned LOCK_CYCLES  = (LOCK_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned FILT_MIN_CLKS = 3;

	// -------------------------------------------------------------------
	// Register indices and address decode
	// -------------------------------------------------------------------
	localparam int unsigned ADDR_IDX_LSB     = 2;
	localparam logic [7:0]  REG_CFG_IDX      = 8'h03;
	localparam logic [7:0]  REG_GPIO_DIR_IDX = 8'h0d;
	localparam logic [7:0]  REG_GPIO_LVL_IDX = 8'h0e;
	localparam logic [7:0]  REG_GPO_EN_IDX   = 8'h0f;
	localparam logic [7:0]  REG_GPO_LVL_IDX  = 8'h10;
	localparam logic [7:0]  REG_STATUS_IDX   = 8'h11;

	// -------------------------------------------------------------------
	// Field positions and reset values
	// -------------------------------------------------------------------
	localparam int unsigned CFG_EDGE_BIT   = 0;
	localparam int unsigned CFG_FILT_BIT   = 1;
	localparam int unsigned CFG_MODE18_BIT = 2;
	localparam logic [7:0]  CFG_RST        = 8'h01;
	localparam logic [3:0]  GPIO_DIR_RST   = 4'h0;
	localparam logic [3:0]  GPIO_LVL_RST   = 4'h0;
	localparam logic [4:0]  GPO_EN_RST     = 5'h00;
	localparam logic [4:0]  GPO_LVL_RST    = 5'h00;
	localparam int unsigned XC_EDGE        = 0;
	localparam int unsigned XC_FILT        = 1;
	localparam int unsigned XC_MODE18      = 2;
	localparam int unsigned XC_RUN         = 3;

	// -------------------------------------------------------------------
	// Pixel word layout
	// -------------------------------------------------------------------
	localparam int unsigned PIX_W       = 27;
	localparam int unsigned PIX_ENA_BIT = 24;
	localparam int unsigned PIX_HSY_BIT = 25;
	localparam int unsigned PIX_VSY_BIT = 26;
	localparam logic [23:0] MODE18_MASK = 24'hfcfcfc;

	// -------------------------------------------------------------------
	// AHB-Lite encodings
	// -------------------------------------------------------------------
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;
	localparam logic        HRESP_OKAY        = 1'b0;

	// Power sequencing states, Gray along down, lock, run.
	typedef enum logic [1:0] {
		PWR_DOWN = 2'b00,
		PWR_LOCK = 2'b01,
		PWR_RUN  = 2'b11
	} pwr_e;

endpackage

/* File: logic/ctrl_signal_filter.sv */
// Minimum pulse width filter for video control signals, one lane per bit.
// Assumes sig_in is already in the pixel clock domain.
`timescale 1ns/100ps
module ctrl_signal_filter
	import pvip_pkg::*;
#(
	parameter int unsigned W        = 2,
	parameter int unsigned MIN_CLKS = FILT_MIN_CLKS
)
(
	// Clock and reset.
	input  wire logic         pix_clk,
	input  wire logic         rst_b,
	// Control and data.
	input  wire logic         enable,
	input  wire logic [W-1:0] sig_in,
	output logic      [W-1:0] sig_out
);

	localparam int unsigned CW = $clog2(MIN_CLKS + 1);

	typedef struct packed {
		logic [W-1:0]         out;
		logic [W-1:0][CW-1:0] cnt;
	} filt_s;

	filt_s st_r;
	filt_s st_nxt;

	// A lane flips only after the new level has been seen MIN_CLKS times in a row.
	always_comb
	begin
		st_nxt = st_r;
		for (int i = 0; i < W; i++)
		begin
			if (!enable)
			begin
				st_nxt.out[i] = sig_in[i];
				st_nxt.cnt[i] = '0;
			end
			else if (sig_in[i] == st_r.out[i])
				st_nxt.cnt[i] = '0;
			else if (st_r.cnt[i] == CW'(MIN_CLKS - 1))
			begin
				st_nxt.out[i] = sig_in[i];
				st_nxt.cnt[i] = '0;
			end
			else
				st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
		end
	end

	// State register.
	always_ff @(posedge pix_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign sig_out = st_r.out;

endmodule // ctrl_signal_filter

/* File: logic/parallel_video_input_port.sv */
// Parallel video input port: pixel capture, control filter, GPIO reuse, power-down.
// Assumes an AHB-Lite master on sys_clk and a video source on pixel_clk.
// Assumes pixel_din and the syncs change just after the rising pixel_clk edge.
//
// Function
// - With the filter on, a horizontal sync or enable pulse passes only if it lasts three pixel clocks.
// - With the filter off, sync and enable pass exactly as sampled.
// - The pixel clock edge used for sampling is chosen by bit 0 of register 0x03.
// - Four two-way pins replace data bits 9, 8, 1, 0, only in 18-bit colour mode.
// - Register-driven outputs 4 to 7 take audio word clock, audio data or data bits 17, 16.
// - Audio bit clock, word clock and data can become register outputs 8, 7 and 6.
// - Power-down input high runs the device; low puts it into power-down.
// - In power-down both serial outputs are high, the PLL stops, registers reset.
// - The frequency select input picks the intermediate-frequency coax mode.
// - Data bits 0, 1, 8, 9 map to pins 0 to 3; bits 16, 17 map to outputs 4 and 5.
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module parallel_video_input_port
	import pvip_pkg::*;
(
	// System clock and reset.
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	// AHB-Lite register slave.
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Video source.
	input  wire logic               pixel_clk,
	input  wire logic [23:0]        pixel_din,
	input  wire logic               horizontal_sync_in,
	input  wire logic               vertical_sync_in,
	input  wire logic               data_enable_in,
	// Captured pixel stream, pixel_clk domain.
	output logic      [PIX_W-1:0]   pixel_word,
	output logic                    pixel_word_valid,
	// General-purpose two-way pins on data bits 0, 1, 8, 9.
	input  wire logic [3:0]         gpio_in,
	output logic      [3:0]         gpio_out,
	output logic      [3:0]         gpio_oe_n,
	// Register outputs on data bits 16, 17.
	output logic      [1:0]         din_hi_out,
	output logic      [1:0]         din_hi_oe_n,
	// Register outputs on audio data, word clock, bit clock.
	output logic      [2:0]         audio_pin_out,
	output logic      [2:0]         audio_pin_oe_n,
	// Control pins.
	input  wire logic               power_down_n,
	input  wire logic               frequency_mode_select,
	input  wire logic               mode_strap,
	// Serial driver and PLL control.
	output logic                    serial_out_p,
	output logic                    serial_out_n,
	output logic                    pll_enable,
	output logic                    coax_if_mode
);

	// -------------------------------------------------------------------
	// System domain state
	// -------------------------------------------------------------------
	typedef struct packed {
		logic        pd_m;
		logic        pd_s;
		logic        fmode_m;
		logic        fmode_s;
		logic        strap_m;
		logic        strap_s;
		logic [3:0]  gpio_m;
		logic [3:0]  gpio_s;
		logic        ph_valid;
		logic        ph_wr;
		logic [7:0]  ph_idx;
		logic [7:0]  cfg;
		logic [3:0]  gpio_dir;
		logic [3:0]  gpio_lvl;
		logic [4:0]  gpo_en;
		logic [4:0]  gpo_lvl;
		logic [31:0] rdata;
		pwr_e        pwr;
		logic [7:0]  lock_cnt;
		logic [3:0]  cfg_x;
	} sys_s;

	sys_s st_r;
	sys_s st_nxt;

	// -------------------------------------------------------------------
	// Pixel domain state
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [3:0]       cfg_m;
		logic [3:0]       cfg_s;
		logic [3:0]       cfg_q; // Settings word once two samples agree.
		logic [PIX_W-1:0] samp;
		logic [PIX_W-1:0] word;
		logic             valid;
	} pix_s;

	pix_s             px_r;
	pix_s             px_nxt;
	logic [PIX_W-1:0] capt_neg_r;
	logic [PIX_W-1:0] raw_word;
	logic [1:0]       filt_out;

	// 18-bit colour mode comes from the strap or from software.
	function automatic logic mode18_of(input sys_s s);
		mode18_of = s.strap_s | s.cfg[CFG_MODE18_BIT];
	endfunction

	// Register read decode; unmapped indices read as zero.
	// STATUS is read-only; the write decode has no branch for it.
	function automatic logic [31:0] reg_read(input logic [7:0] idx, input sys_s s);
		logic [31:0] d;
		d = 32'h0;
		case (idx)
			REG_CFG_IDX:      d[7:0] = s.cfg;
			REG_GPIO_DIR_IDX: d[3:0] = s.gpio_dir;
			REG_GPIO_LVL_IDX: d[3:0] = s.gpio_lvl;
			REG_GPO_EN_IDX:   d[4:0] = s.gpo_en;
			REG_GPO_LVL_IDX:  d[4:0] = s.gpo_lvl;
			REG_STATUS_IDX:   d[6:0] = {mode18_of(s), s.fmode_s, (s.pwr == PWR_RUN), s.gpio_s};
			default:          d = 32'h0;
		endcase
		reg_read = d;
	endfunction

	// -------------------------------------------------------------------
	// System domain next state
	// -------------------------------------------------------------------
	// Synchronisers, power sequencing, bus slave and register file.
	always_comb
	begin
		st_nxt = st_r;
		// Two-stage synchronisers for the pins that come from outside sys_clk.
		st_nxt.pd_m    = power_down_n;
		st_nxt.pd_s    = st_r.pd_m;
		st_nxt.fmode_m = frequency_mode_select;
		st_nxt.fmode_s = st_r.fmode_m;
		st_nxt.strap_m = mode_strap;
		st_nxt.strap_s = st_r.strap_m;
		st_nxt.gpio_m  = gpio_in;
		st_nxt.gpio_s  = st_r.gpio_m;

		// Power sequencing: the PLL is given a lock time after power-down ends.
		// The lock counter restarts from zero each time power-down ends, so a short
		// glitch on the pin cannot shorten the lock time.
		case (st_r.pwr)
			PWR_DOWN:
			begin
				st_nxt.lock_cnt = 8'h00;
				if (st_r.pd_s)
					st_nxt.pwr = PWR_LOCK;
			end
			PWR_LOCK:
			begin
				if (!st_r.pd_s)
					st_nxt.pwr = PWR_DOWN;
				else if (st_r.lock_cnt == 8'(LOCK_CYCLES - 1))
					st_nxt.pwr = PWR_RUN;
				else
					st_nxt.lock_cnt = st_r.lock_cnt + 8'h01;
			end
			PWR_RUN:
			begin
				if (!st_r.pd_s)
					st_nxt.pwr = PWR_DOWN;
			end
			default:
				st_nxt.pwr = PWR_DOWN;
		endcase

		// Data phase of a write stores hwdata into the addressed register.
		// Writes to unmapped or read-only indices fall to the default and are lost.
		if (st_r.ph_valid && st_r.ph_wr)
		begin
			case (st_r.ph_idx)
				REG_CFG_IDX:      st_nxt.cfg = hwdata[7:0];
				REG_GPIO_DIR_IDX: st_nxt.gpio_dir = hwdata[3:0];
				REG_GPIO_LVL_IDX: st_nxt.gpio_lvl = hwdata[3:0];
				REG_GPO_EN_IDX:   st_nxt.gpo_en = hwdata[4:0];
				REG_GPO_LVL_IDX:  st_nxt.gpo_lvl = hwdata[4:0];
				default:          st_nxt.cfg = st_nxt.cfg;
			endcase
		end

		// Address phase is taken when selected, active and the bus is ready.
		// The transfer size is not decoded: every register is one aligned word.
		st_nxt.ph_valid = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
		st_nxt.ph_wr    = hwrite;
		st_nxt.ph_idx   = haddr[ADDR_IDX_LSB +: 8];

		// Power-down holds every control register at its reset value.
		// A write in the same cycle is overridden, so nothing survives power-down.
		if (!st_r.pd_s)
		begin
			st_nxt.cfg      = CFG_RST;
			st_nxt.gpio_dir = GPIO_DIR_RST;
			st_nxt.gpio_lvl = GPIO_LVL_RST;
			st_nxt.gpo_en   = GPO_EN_RST;
			st_nxt.gpo_lvl  = GPO_LVL_RST;
		end

		// Read data is built from the updated registers so a write just before is seen.
		if (st_nxt.ph_valid && !hwrite)
			st_nxt.rdata = reg_read(haddr[ADDR_IDX_LSB +: 8], st_nxt);

		// Registered copy of the settings that cross into the pixel domain.
		// Each bit stays steady for many pixel clocks after a write; the pixel side
		// still waits for two agreeing samples before it acts on the word.
		st_nxt.cfg_x[XC_EDGE]   = st_r.cfg[CFG_EDGE_BIT];
		st_nxt.cfg_x[XC_FILT]   = st_r.cfg[CFG_FILT_BIT];
		st_nxt.cfg_x[XC_MODE18] = mode18_of(st_r);
		st_nxt.cfg_x[XC_RUN]    = (st_r.pwr == PWR_RUN);
	end

	// System domain register.
	// Only constants are loaded on reset; the synchronisers start from the low
	// level and follow their pins two clocks after release.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r          <= '0;
			st_r.cfg      <= CFG_RST;
			st_r.gpio_dir <= GPIO_DIR_RST;
			st_r.gpio_lvl <= GPIO_LVL_RST;
			st_r.gpo_en   <= GPO_EN_RST;
			st_r.gpo_lvl  <= GPO_LVL_RST;
			st_r.pwr      <= PWR_DOWN;
		end
		else
			st_r <= st_nxt;
	end

	// -------------------------------------------------------------------
	// Bus answers and pin drivers
	// -------------------------------------------------------------------
	// Zero-wait slave that always answers OKAY.
	// With no wait states a master may issue transfers back to back, and a read
	// right after a write to the same register already sees the new value.
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = st_r.rdata;

	// Two-way pins drive only in 18-bit mode and when set as outputs.
	// Pins that are not driven are left to their outside levels.
	assign gpio_out  = st_r.gpio_lvl;
	assign gpio_oe_n = ~({4{mode18_of(st_r)}} & st_r.gpio_dir);

	// Data bits 16 and 17 become outputs 4 and 5 in 18-bit mode.
	assign din_hi_out  = st_r.gpo_lvl[1:0];
	assign din_hi_oe_n = ~({2{mode18_of(st_r)}} & st_r.gpo_en[1:0]);

	// Audio data, word clock and bit clock become outputs 6, 7 and 8.
	assign audio_pin_out  = st_r.gpo_lvl[4:2];
	assign audio_pin_oe_n = ~st_r.gpo_en[4:2];

	// Serial pair idles high on both legs while powered down.
	// The serializer lives elsewhere; only its idle levels are set here.
	assign serial_out_p = 1'b1;
	assign serial_out_n = (st_r.pwr == PWR_DOWN);
	assign pll_enable   = (st_r.pwr != PWR_DOWN);
	assign coax_if_mode = st_r.fmode_s;

	// -------------------------------------------------------------------
	// Pixel capture
	// -------------------------------------------------------------------
	// Falling edge copy of the inputs for the falling edge strobe setting.
	// The copy is used at the following rising edge, half a period later, so
	// both settings feed the same rising edge pipeline.
	always_ff @(negedge pixel_clk or negedge rst_b)
	begin
		if (!rst_b)
			capt_neg_r <= '0;
		else
			capt_neg_r <= {vertical_sync_in, horizontal_sync_in, data_enable_in, pixel_din};
	end

	// Edge select: 1 takes the rising edge sample, 0 the falling edge one.
	assign raw_word = px_r.cfg_q[XC_EDGE] ?
		{vertical_sync_in, horizontal_sync_in, data_enable_in, pixel_din} :
		capt_neg_r;

	// Filter for horizontal sync and data enable; vertical sync is never filtered.
	// An accepted change reaches the word two pixel clocks after the data beside it.
	ctrl_signal_filter #(
		.W        (2),
		.MIN_CLKS (FILT_MIN_CLKS)
	) u_ctrl_filter (
		.pix_clk (pixel_clk),
		.rst_b   (rst_b),
		.enable  (px_r.cfg_q[XC_FILT]),
		.sig_in  ({raw_word[PIX_HSY_BIT], raw_word[PIX_ENA_BIT]}),
		.sig_out (filt_out)
	);

	// Settings sync, sample stage and word assembly.
	always_comb
	begin
		px_nxt = px_r;
		px_nxt.cfg_m = st_r.cfg_x;
		px_nxt.cfg_s = px_r.cfg_m;
		// Settings act only after two agreeing samples, so bits written together
		// also switch together on this side.
		if (px_r.cfg_s == px_r.cfg_m)
			px_nxt.cfg_q = px_r.cfg_s;
		px_nxt.samp  = raw_word;
		if (px_r.cfg_q[XC_RUN])
		begin
			px_nxt.word[PIX_VSY_BIT] = px_r.samp[PIX_VSY_BIT];
			px_nxt.word[PIX_HSY_BIT] = filt_out[1];
			px_nxt.word[PIX_ENA_BIT] = filt_out[0];
			if (px_r.cfg_q[XC_MODE18])
				px_nxt.word[23:0] = px_r.samp[23:0] & MODE18_MASK;
			else
				px_nxt.word[23:0] = px_r.samp[23:0];
			px_nxt.valid = 1'b1;
		end
		else
		begin
			px_nxt.word  = '0;
			px_nxt.valid = 1'b0;
		end
	end

	// Pixel domain register.
	// The pixel domain is reset by rst_b directly; settings reach it only through
	// the synchroniser stages above.
	always_ff @(posedge pixel_clk or negedge rst_b)
	begin
		if (!rst_b)
			px_r <= '0;
		else
			px_r <= px_nxt;
	end

	// Word and valid are both straight register outputs.
	assign pixel_word       = px_r.word;
	assign pixel_word_valid = px_r.valid;

endmodule // parallel_video_input_port

/* File: bench/pvip_sva.sv */
// Concurrent checks on the pins of the parallel video input port.
// Assumes it is bound to parallel_video_input_port from the bench top.
`timescale 1ns/100ps
module pvip_sva
	import pvip_pkg::*;
(
	// Clocks and reset.
	input wire logic             sys_clk,
	input wire logic             pixel_clk,
	input wire logic             rst_b,
	// Watched pins.
	input wire logic             power_down_n,
	input wire logic             frequency_mode_select,
	input wire logic             vertical_sync_in,
	input wire logic [PIX_W-1:0] pixel_word,
	input wire logic             pixel_word_valid,
	input wire logic             serial_out_p,
	input wire logic             serial_out_n,
	input wire logic             pll_enable,
	input wire logic             coax_if_mode
);
	// -------------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------------
	// Power-down pin held low long enough to pass the synchroniser.
	sequence s_pd_held;
		(!power_down_n)[*4];
	endsequence
	property p_pd_idle;
		@(posedge sys_clk) disable iff (!rst_b) s_pd_held |-> serial_out_n && !pll_enable;
	endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("power-down idle levels wrong");
	property p_drv_pair;
		@(posedge sys_clk) disable iff (!rst_b) serial_out_p && (serial_out_n != pll_enable);
	endproperty
	a_drv_pair: assert property (p_drv_pair) else $error("driver and pll levels disagree");
	property p_pll_rise;
		@(posedge sys_clk) disable iff (!rst_b)
			$rose(pll_enable) |-> $past(power_down_n, 3) || $past(power_down_n, 4);
	endproperty
	a_pll_rise: assert property (p_pll_rise) else $error("pll started without run level");
	property p_pll_fall;
		@(posedge sys_clk) disable iff (!rst_b)
			$fell(pll_enable) |-> !$past(power_down_n, 3) || !$past(power_down_n, 4);
	endproperty
	a_pll_fall: assert property (p_pll_fall) else $error("pll stopped without power-down");
	property p_coax_cause;
		@(posedge sys_clk) disable iff (!rst_b)
			$changed(coax_if_mode) |-> coax_if_mode == $past(frequency_mode_select, 2);
	endproperty
	a_coax_cause: assert property (p_coax_cause) else $error("coax mode changed wrongly");
	property p_coax_level;
		@(posedge sys_clk) disable iff (!rst_b) frequency_mode_select[*3] |-> coax_if_mode;
	endproperty
	a_coax_level: assert property (p_coax_level) else $error("coax mode not entered");
	property p_word_idle;
		@(posedge pixel_clk) disable iff (!rst_b)
			!pixel_word_valid && !$past(pixel_word_valid) |-> pixel_word == '0;
	endproperty
	a_word_idle: assert property (p_word_idle) else $error("pixel word not idle");
	property p_vs_lag;
		@(posedge pixel_clk) disable iff (!rst_b) pixel_word_valid && $past(pixel_word_valid, 3)
			|-> pixel_word[PIX_VSY_BIT] == $past(vertical_sync_in, 2);
	endproperty
	a_vs_lag: assert property (p_vs_lag) else $error("vertical sync not carried");
endmodule // pvip_sva

/* File: bench/video_source_model.sv */
// Behavioural video source driving the pixel side of the port.
// Assumes the bench sets the sync pulse length; the pixel clock runs free.
`timescale 1ns/100ps
module video_source_model
(
	// Line shape from the bench.
	input wire logic [7:0]  pulse_len,
	// Video source pins.
	output logic            pixel_clk,
	output logic [23:0]     pixel_din,
	output logic            horizontal_sync_in,
	output logic            vertical_sync_in,
	output logic            data_enable_in
);
	logic [22:0] cnt;
	logic [8:0]  pos;
	// Free 80 ns pixel clock, offset from the system clock.
	initial
	begin
		{pixel_clk, cnt, pos, pixel_din} = '0;
		{horizontal_sync_in, vertical_sync_in, data_enable_in} = '0;
		#13;
		forever #40 pixel_clk = ~pixel_clk;
	end
	// Even word after the rise, odd after the fall: a rising edge sample sees bit 0 high.
	always @(posedge pixel_clk)
	begin
		cnt <= cnt + 23'h1;
		pixel_din <= {cnt, 1'b0};
		pos <= (pos == 9'd279) ? 9'h0 : pos + 9'h1;
		horizontal_sync_in <= (pos % 9'd140) < {1'b0, pulse_len};
		data_enable_in <= (pos % 9'd140) < {1'b0, pulse_len};
		vertical_sync_in <= pos < 9'd140;
	end
	// Second half of each pixel period carries the odd word.
	always @(negedge pixel_clk)
		pixel_din[0] <= 1'b1;
endmodule // video_source_model

/* File: bench/test_parallel_video_input_port.sv */
// Self-checking bench for the parallel video input port.
// Assumes pvip_pkg, the design, the source model and the checker are compiled first.
`timescale 1ns/100ps
module test_parallel_video_input_port
	import pvip_pkg::*;
;
	// -------------------------------------------------------------------
	// Signals and instances
	// -------------------------------------------------------------------
	logic sys_clk, rst_b, hwrite, hreadyout, hresp, pixel_clk, pixel_word_valid;
	logic horizontal_sync_in, vertical_sync_in, data_enable_in, mode_strap;
	logic power_down_n, frequency_mode_select, serial_out_p, serial_out_n;
	logic pll_enable, coax_if_mode;
	logic [1:0] htrans, din_hi_out, din_hi_oe_n;
	logic [2:0] audio_pin_out, audio_pin_oe_n;
	logic [3:0] gpio_in, gpio_out, gpio_oe_n;
	logic [7:0] pulse_len;
	logic [23:0] pixel_din;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [PIX_W-1:0] pixel_word, pw;
	int errors, checked, w[2], last[2];

	parallel_video_input_port u_dut (.sys_clk, .rst_b, .hsel(1'b1), .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.pixel_clk, .pixel_din, .horizontal_sync_in, .vertical_sync_in, .data_enable_in,
		.pixel_word, .pixel_word_valid, .gpio_in, .gpio_out, .gpio_oe_n, .din_hi_out,
		.din_hi_oe_n, .audio_pin_out, .audio_pin_oe_n, .power_down_n,
		.frequency_mode_select, .mode_strap, .serial_out_p, .serial_out_n, .pll_enable,
		.coax_if_mode);
	video_source_model u_src (.pulse_len, .pixel_clk, .pixel_din, .horizontal_sync_in,
		.vertical_sync_in, .data_enable_in);

	// Pin level: the port where it drives, an outside level of 0101 elsewhere.
	assign gpio_in = (gpio_out & ~gpio_oe_n) | (4'h5 & gpio_oe_n);

	// System clock, 5 ns.
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Width of the last filtered enable and sync pulse in the pixel word.
	always @(negedge pixel_clk)
		for (int i = 0; i < 2; i++)
			if (pixel_word[PIX_ENA_BIT+i])
				w[i]++;
			else if (w[i] != 0)
			begin
				last[i] = w[i];
				w[i] = 0;
			end

	// -------------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, s, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One single AHB-Lite word transfer; read data lands in rdat.
	task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask

	task conclude;
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task t_regs;
		bus(1'b0, REG_CFG_IDX, 32'h0);
		chk(rdat, {24'h0, CFG_RST});
		chk(hresp, HRESP_OKAY);
		bus(1'b0, REG_GPIO_DIR_IDX, 32'h0);
		chk(rdat, {28'h0, GPIO_DIR_RST});
		bus(1'b0, REG_GPO_EN_IDX, 32'h0);
		chk(rdat, {27'h0, GPO_EN_RST});
		bus(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
	endtask

	task t_edge;
		@(negedge pixel_clk) pw = pixel_word;
		@(negedge pixel_clk) chk(pixel_word[0], 1'b1);
		chk(pixel_word[23:0] - pw[23:0], 24'h2);
		bus(1'b1, REG_CFG_IDX, 32'h0);
		cyc(100);
		@(negedge pixel_clk) chk(pixel_word[0], 1'b0);
		bus(1'b1, REG_CFG_IDX, 32'h1);
	endtask

	task t_gpio;
		bus(1'b1, REG_GPIO_DIR_IDX, 32'hf);
		bus(1'b1, REG_GPIO_LVL_IDX, 32'ha);
		bus(1'b1, REG_GPO_EN_IDX, 32'h1f);
		bus(1'b1, REG_GPO_LVL_IDX, 32'h15);
		cyc(2);
		chk(gpio_out, 4'ha);
		chk(gpio_oe_n, 4'hf);
		chk({din_hi_oe_n, din_hi_out}, 4'hd);
		chk({audio_pin_oe_n, audio_pin_out}, 6'h05);
		bus(1'b0, REG_STATUS_IDX, 32'h0);
		chk(rdat[6:0], 7'h15);
		mode_strap <= 1'b1;
		cyc(100);
		chk({din_hi_oe_n, gpio_oe_n}, 6'h00);
		@(negedge pixel_clk) chk(pixel_word[23:0] & ~MODE18_MASK, 24'h0);
		bus(1'b0, REG_STATUS_IDX, 32'h0);
		chk({rdat[6], rdat[3:0]}, 5'h1a);
		mode_strap <= 1'b0;
	endtask

	task t_filter;
		logic [7:0] cf, ln;
		int ex;
		for (int k = 0; k < 4; k++)
		begin
			cf = (k == 0) ? 8'h01 : 8'h03;
			ln = (k == 0) ? 8'h01 : 8'(k);
			ex = (k == 0) ? 1 : ((k == 3) ? 3 : 0);
			bus(1'b1, REG_CFG_IDX, {24'h0, cf});
			pulse_len <= ln;
			cyc(200);
			last = '{0, 0};
			cyc(4600);
			chk(last[0], ex);
			chk(last[1], ex);
		end
		pulse_len <= 8'h3;
	endtask

	task t_power;
		bus(1'b1, REG_CFG_IDX, 32'h7);
		power_down_n <= 1'b0;
		cyc(10);
		chk({serial_out_p, serial_out_n, pll_enable}, 3'b110);
		bus(1'b0, REG_CFG_IDX, 32'h0);
		chk(rdat, {24'h0, CFG_RST});
		cyc(100);
		chk({pixel_word_valid, pixel_word}, 28'h0);
		power_down_n <= 1'b1;
		cyc(10);
		chk(pll_enable, 1'b1);
		cyc(LOCK_CYCLES + 20);
		bus(1'b0, REG_STATUS_IDX, 32'h0);
		chk(rdat[4], 1'b1);
	endtask

	task t_frequency_mode_select;
		frequency_mode_select <= 1'b1;
		cyc(4);
		chk(coax_if_mode, 1'b1);
		bus(1'b0, REG_STATUS_IDX, 32'h0);
		chk(rdat[5], 1'b1);
		frequency_mode_select <= 1'b0;
	endtask

	// -------------------------------------------------------------------
	// Sequence and watchdog
	// -------------------------------------------------------------------
	initial
	begin
		{rst_b, hwrite, htrans, haddr, hwdata, mode_strap, frequency_mode_select} = '0;
		power_down_n = 1'b1;
		pulse_len = 8'h3;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		cyc(400);
		t_regs();
		t_edge();
		t_gpio();
		t_filter();
		t_power();
		t_frequency_mode_select();
		conclude();
	end

	// Whole run needs about 100 us; a hang is cut well past that.
	initial
	begin
		#400000;
		errors++;
		conclude();
	end
endmodule // test_parallel_video_input_port

bind parallel_video_input_port pvip_sva u_sva (.sys_clk(sys_clk), .pixel_clk(pixel_clk),
	.rst_b(rst_b), .power_down_n(power_down_n), .frequency_mode_select(frequency_mode_select),
	.vertical_sync_in(vertical_sync_in), .pixel_word(pixel_word),
	.pixel_word_valid(pixel_word_valid), .serial_out_p(serial_out_p),
	.serial_out_n(serial_out_n), .pll_enable(pll_enable), .coax_if_mode(coax_if_mode));
